// [include/idc_consts.svh]
`ifndef IDC_CONSTS_SVH
`define IDC_CONSTS_SVH

// ------------------------------------------------------------
// Instruction word layout
// ------------------------------------------------------------
`define IDC_WORD_W          12
`define IDC_FADDR_W         7
`define IDC_FIELD_F_LSB     0
`define IDC_FIELD_F_MSB     4
`define IDC_FIELD_D_BIT     5
`define IDC_FIELD_B_LSB     5
`define IDC_FIELD_B_MSB     7
`define IDC_FIELD_K8_MSB    7
`define IDC_FIELD_K9_MSB    8

// ------------------------------------------------------------
// File addresses with side effects
// ------------------------------------------------------------
`define IDC_TIMER_ADDR      7'h01
`define IDC_PCL_ADDR        7'h02
`define IDC_TRISTATE_PORT   3'h6

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define IDC_TIMEOUT_RESET   1'b1
`define IDC_PWRDN_RESET     1'b1
`define IDC_PERIODS_PER_CYC 4

`endif

// [include/idc_pkg.sv]
`default_nettype none
package idc_pkg;
	typedef enum logic [4:0] {
		ALU_NONE, ALU_OR, ALU_AND, ALU_XOR, ALU_ADD, ALU_SUB, ALU_MOVE,
		ALU_COM, ALU_INC, ALU_DEC, ALU_RRC, ALU_RLC, ALU_SWAP,
		ALU_BCLR, ALU_BSET, ALU_ZERO, ALU_PASS_ACC, ALU_LIT
	} idc_alu_e;

	typedef enum logic [1:0] {SK_NONE, SK_ZERO, SK_BIT_CLR, SK_BIT_SET} idc_skip_e;

	typedef enum logic [2:0] {PC_INC, PC_GOTO, PC_CALL, PC_RET, PC_FILE} idc_pc_e;

	typedef struct packed {
		idc_alu_e    alu;
		idc_skip_e   skip;
		idc_pc_e     pc_op;
		logic        acc_write;
		logic        file_write;
		logic [6:0]  file_addr;
		logic [2:0]  bit_sel;
		logic [7:0]  bit_mask;
		logic [8:0]  literal;
		logic        use_literal;
		logic        upd_c;
		logic        upd_dc;
		logic        upd_z;
		logic        pc_bit9_clear;
		logic        sleep;
		logic        wdt_clear;
		logic        option_load;
		logic        tristate_load_op;
		logic        prescaler_clear;
	} idc_ctl_s;
endpackage
`default_nettype wire

// [hw/idc_phase_gen.sv]
`timescale 1ns/1ns
`default_nettype none
`include "idc_consts.svh"
module idc_phase_gen #(
	parameter int PERIODS = `IDC_PERIODS_PER_CYC
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	output var  logic cycle_start,
	output var  logic cycle_end
);
	localparam int CW = (PERIODS > 1) ? $clog2(PERIODS) : 1;

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic          next_start;
	logic          next_end;

	// ------------------------------------------------------------
	// Oscillator period counter
	// ------------------------------------------------------------
	// Wraps every PERIODS clocks; start and end are registered pulses
	always_comb begin
		next_cnt   = (cnt == CW'(PERIODS - 1)) ? '0 : cnt + CW'(1);
		next_start = (next_cnt == '0);
		next_end   = (next_cnt == CW'(PERIODS - 1));
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt         <= '0;
			cycle_start <= 1'b0;
			cycle_end   <= 1'b0;
		end else begin
			cnt         <= next_cnt;
			cycle_start <= next_start;
			cycle_end   <= next_end;
		end
	end
endmodule
`default_nettype wire

// [hw/idc_decoder.sv]
`timescale 1ns/1ns
`default_nettype none
`include "idc_consts.svh"
// Functional notes
// - One 12-bit word, opcode plus operand fields
// - Destination bit 0 writes accumulator, 1 file
// - Bit field selects one of eight bits
// - Literal is 8 or 9 bits wide
// - File address spans 0x00 to 0x1F
// - One cycle; two on skip or branch
// - Instruction cycle is four clock periods
// - Nibble 0001: or, and, xor, add
// - Nibble 0010: move, complement, increment, decrement-skip
// - Nibble 0011: rotates, swap, increment-skip
// - Nibbles 0100-0111: bit clear/set/test-skip
// - Test-skip-if-set skips when bit is one
// - Nibbles 1100-1111: literal move, or, and, xor
// - Nibble 1000 returns with literal, two cycles
// - Standby word updates timeout and powerdown bits
// - Program counter writes except goto clear bit9
// - Met skip discards prefetched word, runs nop
// - Tristate load port six copies accumulator
// - Timer write clears prescaler when assigned
module idc_decoder (
	input  wire logic            mclk,
	input  wire logic            rst_n,
	input  wire logic [11:0]     instr_word,
	input  wire logic            file_bit_value,
	input  wire logic            alu_zero,
	input  wire logic            prescaler_on_timer,
	output var  idc_pkg::idc_ctl_s ctl,
	output var  logic            discard,
	output var  logic            timeout_status_bit,
	output var  logic            powerdown_status_bit,
	output logic                 cycle_start,
	output logic                 cycle_end
);
	import idc_pkg::*;

	typedef enum logic {ST_RUN, ST_FLUSH} idc_state_e;

	idc_state_e state;
	idc_state_e next_state;
	idc_ctl_s   next_ctl;
	logic       next_discard;
	logic       next_timeout;
	logic       next_powerdown;
	logic       skip_met;

	// ------------------------------------------------------------
	// Instruction cycle timing
	// ------------------------------------------------------------
	// Four clock periods per instruction cycle
	idc_phase_gen #(.PERIODS(`IDC_PERIODS_PER_CYC)) u_idc_phase_gen (
		.mclk        (mclk),
		.rst_n       (rst_n),
		.cycle_start (cycle_start),
		.cycle_end   (cycle_end)
	);

	// ------------------------------------------------------------
	// Word decode
	// ------------------------------------------------------------
	function automatic idc_ctl_s decode(input logic [11:0] w, input logic psc_tmr);
		idc_ctl_s c;
		logic     wr_f;
		c = '0;
		c.file_addr = {2'b00, w[`IDC_FIELD_F_MSB:`IDC_FIELD_F_LSB]};
		c.bit_sel   = w[`IDC_FIELD_B_MSB:`IDC_FIELD_B_LSB];
		c.bit_mask  = 8'h01 << c.bit_sel;
		c.literal   = {1'b0, w[`IDC_FIELD_K8_MSB:0]};
		c.file_write = w[`IDC_FIELD_D_BIT];
		c.acc_write  = !w[`IDC_FIELD_D_BIT];
		casez (w)
		12'b0000_0000_0000: c.acc_write = 1'b0;
		12'b0000_0000_0010: begin
			c.option_load = 1'b1;
			c.acc_write   = 1'b0;
		end
		12'b0000_0000_0011: begin
			c.sleep     = 1'b1;
			c.acc_write = 1'b0;
		end
		12'b0000_0000_0100: begin
			c.wdt_clear = 1'b1;
			c.acc_write = 1'b0;
		end
		12'b0000_0000_0???: begin
			c.tristate_load_op = (w[2:0] == `IDC_TRISTATE_PORT);
			c.acc_write = 1'b0;
		end
		12'b0000_001?_????: begin
			c.alu        = ALU_PASS_ACC;
			c.file_write = 1'b1;
			c.acc_write  = 1'b0;
		end
		12'b0000_0100_0000: begin
			c.alu   = ALU_ZERO;
			c.upd_z = 1'b1;
		end
		12'b0000_011?_????: begin
			c.alu        = ALU_ZERO;
			c.upd_z      = 1'b1;
			c.file_write = 1'b1;
			c.acc_write  = 1'b0;
		end
		12'b0000_10??_????: begin
			c.alu = ALU_SUB;
			{c.upd_c, c.upd_dc, c.upd_z} = 3'b111;
		end
		12'b0000_11??_????: begin
			c.alu   = ALU_DEC;
			c.upd_z = 1'b1;
		end
		12'b0001_????_????: begin
			c.alu    = w[7] ? (w[6] ? ALU_ADD : ALU_XOR) : (w[6] ? ALU_AND : ALU_OR);
			c.upd_z  = 1'b1;
			c.upd_c  = (w[7:6] == 2'b11);
			c.upd_dc = (w[7:6] == 2'b11);
		end
		12'b0010_????_????: begin
			c.alu   = w[7] ? (w[6] ? ALU_DEC : ALU_INC) : (w[6] ? ALU_COM : ALU_MOVE);
			c.upd_z = (w[7:6] != 2'b11);
			c.skip  = (w[7:6] == 2'b11) ? SK_ZERO : SK_NONE;
		end
		12'b0011_????_????: begin
			c.alu   = w[7] ? (w[6] ? ALU_INC : ALU_SWAP) : (w[6] ? ALU_RLC : ALU_RRC);
			c.upd_c = !w[7];
			c.skip  = (w[7:6] == 2'b11) ? SK_ZERO : SK_NONE;
		end
		12'b01??_????_????: begin
			c.acc_write  = 1'b0;
			c.file_write = !w[9];
			c.alu        = w[9] ? ALU_NONE : (w[8] ? ALU_BSET : ALU_BCLR);
			c.skip       = w[9] ? (w[8] ? SK_BIT_SET : SK_BIT_CLR) : SK_NONE;
		end
		12'b1000_????_????: begin
			c.alu = ALU_LIT;
			c.use_literal = 1'b1;
			c.pc_op       = PC_RET;
			c.file_write  = 1'b0;
			c.acc_write   = 1'b1;
		end
		12'b1001_????_????: begin
			c.pc_op      = PC_CALL;
			c.file_write = 1'b0;
			c.acc_write  = 1'b0;
		end
		12'b101?_????_????: begin
			c.pc_op      = PC_GOTO;
			c.literal    = w[`IDC_FIELD_K9_MSB:0];
			c.file_write = 1'b0;
			c.acc_write  = 1'b0;
		end
		12'b11??_????_????: begin
			c.alu = w[9] ? (w[8] ? ALU_XOR : ALU_AND) : (w[8] ? ALU_OR : ALU_LIT);
			c.use_literal = 1'b1;
			c.upd_z       = (w[9:8] != 2'b00);
			c.file_write  = 1'b0;
			c.acc_write   = 1'b1;
		end
		default: begin
			c.file_write = 1'b0;
			c.acc_write  = 1'b0;
		end
		endcase
		// Writes back to the timer or the low program counter carry side effects
		wr_f = c.file_write;
		c.prescaler_clear = wr_f && psc_tmr && (c.file_addr == `IDC_TIMER_ADDR);
		if (wr_f && (c.file_addr == `IDC_PCL_ADDR)) begin
			c.pc_op = PC_FILE;
		end
		c.pc_bit9_clear = (c.pc_op == PC_CALL) || (c.pc_op == PC_RET) ||
			(c.pc_op == PC_FILE);
		return c;
	endfunction

	// ------------------------------------------------------------
	// Skip and branch sequencing
	// ------------------------------------------------------------
	// Skip tests are sampled at cycle end, after the datapath settles
	always_comb begin
		case (ctl.skip)
		SK_ZERO:    skip_met = alu_zero;
		SK_BIT_CLR: skip_met = !file_bit_value;
		SK_BIT_SET: skip_met = file_bit_value;
		default:    skip_met = 1'b0;
		endcase
	end

	// Decode latches at cycle start; a flushed slot decodes as nop
	always_comb begin
		next_ctl       = ctl;
		next_state     = state;
		next_discard   = discard;
		next_timeout   = timeout_status_bit;
		next_powerdown = powerdown_status_bit;
		if (cycle_start) begin
			next_ctl = (state == ST_FLUSH) ? decode(12'h000, 1'b0)
				: decode(instr_word, prescaler_on_timer);
		end
		if (cycle_end) begin
			case (state)
			ST_RUN: begin
				if (skip_met || (ctl.pc_op != PC_INC)) begin
					next_state   = ST_FLUSH;
					next_discard = 1'b1;
				end
			end
			ST_FLUSH: begin
				next_state   = ST_RUN;
				next_discard = 1'b0;
			end
			default: next_state = ST_RUN;
			endcase
			if (ctl.sleep) begin
				next_timeout   = 1'b1;
				next_powerdown = 1'b0;
			end else if (ctl.wdt_clear) begin
				next_timeout   = 1'b1;
				next_powerdown = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctl                  <= '0;
			state                <= ST_RUN;
			discard              <= 1'b0;
			timeout_status_bit   <= `IDC_TIMEOUT_RESET;
			powerdown_status_bit <= `IDC_PWRDN_RESET;
		end else begin
			ctl                  <= next_ctl;
			state                <= next_state;
			discard              <= next_discard;
			timeout_status_bit   <= next_timeout;
			powerdown_status_bit <= next_powerdown;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_cycle_len: assert property (cycle_start |=> !cycle_start [*3] ##1 cycle_start)
		else $error("instruction cycle is not four clocks");
	a_flush_nop: assert property (cycle_start && state == ST_FLUSH |=>
		ctl.alu == ALU_NONE && !ctl.acc_write && !ctl.file_write)
		else $error("discarded slot did not run as nop");
	a_branch_two: assert property (cycle_end && state == ST_RUN &&
		ctl.pc_op != PC_INC |=> discard ##4 !discard)
		else $error("branch did not take exactly two cycles");
	a_plain_one: assert property (cycle_end && state == ST_RUN &&
		ctl.pc_op == PC_INC && ctl.skip == SK_NONE |=> !discard)
		else $error("plain instruction took a second cycle");
	a_skip_set: assert property (cycle_end && state == ST_RUN &&
		ctl.skip == SK_BIT_SET && file_bit_value |=> discard)
		else $error("test-skip-if-set did not skip");
	a_dest_sel: assert property (cycle_start && state == ST_RUN &&
		instr_word[11:8] == 4'h1 |=> ctl.file_write == $past(instr_word[5]) &&
		ctl.acc_write == !$past(instr_word[5]))
		else $error("destination bit misrouted");
	a_bit_field: assert property (cycle_start && state == ST_RUN &&
		instr_word[11:8] == 4'h5 |=> ctl.alu == ALU_BSET &&
		ctl.bit_mask == (8'h01 << $past(instr_word[7:5])))
		else $error("bit set mask wrong");
	a_goto_lit: assert property (cycle_start && state == ST_RUN &&
		instr_word[11:9] == 3'b101 |=> ctl.literal == $past(instr_word[8:0]) &&
		!ctl.pc_bit9_clear)
		else $error("goto literal or bit9 wrong");
	// Call and return words taken from the bus must clear bit9, not only the decoded op
	a_pc_bit9: assert property (cycle_start && state == ST_RUN &&
		instr_word[11:9] == 3'b100 |=> ctl.pc_bit9_clear)
		else $error("call or return kept bit9");
	a_sleep_bits: assert property (cycle_end && ctl.sleep |=> timeout_status_bit &&
		!powerdown_status_bit)
		else $error("standby status bits wrong");
	a_psc_clear: assert property (ctl.prescaler_clear |-> ctl.file_write &&
		ctl.file_addr == `IDC_TIMER_ADDR)
		else $error("prescaler cleared without timer write");
	a_psc_timer: assert property (cycle_start && state == ST_RUN && prescaler_on_timer &&
		instr_word[11:5] == 7'h0f && instr_word[4:0] == 5'h01 |=> ctl.prescaler_clear)
		else $error("timer add to file kept prescaler");

	c_skip_taken: cover property (cycle_end && skip_met ##1 discard);
	c_call: cover property (cycle_start ##1 ctl.pc_op == PC_CALL);
	c_sleep: cover property (cycle_end && ctl.sleep);
	c_tristate: cover property (ctl.tristate_load_op);
endmodule
`default_nettype wire

// [verification/idc_prog_mem.sv]
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Program memory model
// ------------------------------------------------------------
module idc_prog_mem (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        cycle_start,
	output var  logic [11:0] instr_word
);
	logic [11:0] mem [0:63];
	logic [5:0]  pc;

	// One word per slot; a discarded slot still uses up its word
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pc <= 6'h00;
		end else if (cycle_start) begin
			pc <= pc + 6'h01;
		end
	end

	// Outside the fetch clock the bus shows the inverse, so a late sample shows up
	assign instr_word = cycle_start ? mem[pc] : ~mem[pc];
endmodule
`default_nettype wire

// [verification/tb_idc_decoder.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_idc_decoder;
	import idc_pkg::*;
	typedef struct {
		logic [11:0] w;
		logic [4:0]  alu;
		logic [1:0]  wr;
		idc_pc_e     pc;
		logic [2:0]  fl;
		logic [2:0]  in;
		logic        dn;
	} idc_row_s;
	localparam logic [4:0] any_alu = 5'h1f;
	logic        mclk;
	logic        rst_n;
	logic [11:0] instr_word;
	logic        file_bit_value;
	logic        alu_zero;
	logic        prescaler_on_timer;
	idc_ctl_s    ctl;
	logic        discard;
	logic        timeout_status_bit;
	logic        powerdown_status_bit;
	logic        cycle_start;
	logic        cycle_end;
	int          errors;
	int          checks_done;
	int          k;
	idc_row_s    rows[$];
	idc_row_s    e;
	logic        dp;
	logic [1:0]  st;

	idc_decoder u_idc_decoder (
		.mclk                 (mclk),
		.rst_n                (rst_n),
		.instr_word           (instr_word),
		.file_bit_value       (file_bit_value),
		.alu_zero             (alu_zero),
		.prescaler_on_timer   (prescaler_on_timer),
		.ctl                  (ctl),
		.discard              (discard),
		.timeout_status_bit   (timeout_status_bit),
		.powerdown_status_bit (powerdown_status_bit),
		.cycle_start          (cycle_start),
		.cycle_end            (cycle_end)
	);
	idc_prog_mem u_idc_prog_mem (
		.mclk        (mclk),
		.rst_n       (rst_n),
		.cycle_start (cycle_start),
		.instr_word  (instr_word)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	always begin
		#5;
		mclk = ~mclk;
	end

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Queue one word with what its slot should decode to
	task automatic add(input logic [11:0] w, input logic [4:0] a, input logic [1:0] wr,
		input idc_pc_e pc, input logic [2:0] fl, input logic [2:0] in = 3'h0,
		input logic dn = 1'h0);
		u_idc_prog_mem.mem[rows.size()] = w;
		rows.push_back('{w, a, wr, pc, fl, in, dn});
	endtask

	task automatic dis(input logic [11:0] w);
		add(w, any_alu, 2'h0, PC_INC, 3'h0);
	endtask

	// Bounded wait for a phase strobe; counts the edges it took
	task automatic wait_for(input logic which, output int n);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while ((which ? cycle_end : cycle_start) !== 1'b1 && n < 9);
	endtask

	task automatic chk_reset();
		chk("reset_ctl", ctl, 64'h0);
		chk("reset_out", {discard, timeout_status_bit, powerdown_status_bit,
			cycle_start, cycle_end}, 5'h0c);
	endtask

	task automatic chk_word(input idc_row_s r);
		if (r.alu != any_alu) chk("alu", ctl.alu, r.alu);
		chk("dest", {ctl.acc_write, ctl.file_write}, r.wr);
		chk("pc_op", ctl.pc_op, r.pc);
		chk("flags", {ctl.upd_c, ctl.upd_dc, ctl.upd_z}, r.fl);
		chk("bit9", ctl.pc_bit9_clear, r.pc inside {PC_CALL, PC_RET, PC_FILE});
		chk("special", {ctl.sleep, ctl.wdt_clear, ctl.option_load, ctl.tristate_load_op},
			{r.w == 12'h003, r.w == 12'h004, r.w == 12'h002, r.w == 12'h006});
		chk("presc", ctl.prescaler_clear, r.wr[0] && r.w[4:0] == 5'h01 && r.in[2]);
		if (!r.w[11] && r.w[11:5] != 7'h00) chk("addr", ctl.file_addr, {2'h0, r.w[4:0]});
		if (r.w[11:10] == 2'h1) chk("mask", {ctl.bit_sel, ctl.bit_mask},
			{r.w[7:5], 8'h01 << r.w[7:5]});
		if (r.w[11:9] == 3'h5) chk("lit9", ctl.literal, r.w[8:0]);
		else if (r.w[11]) chk("lit8", ctl.literal, {1'h0, r.w[7:0]});
		if (r.w[11:10] == 2'h3) chk("use_lit", ctl.use_literal, 1'h1);
	endtask

	// ------------------------------------------------------------
	// Program and checks
	// ------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		{prescaler_on_timer, file_bit_value, alu_zero} = 3'h0;
		errors = 0;
		checks_done = 0;
		foreach (u_idc_prog_mem.mem[j]) u_idc_prog_mem.mem[j] = 12'h000;
		add(12'h000, ALU_NONE, 2'h0, PC_INC, 3'h0);
		add(12'h105, ALU_OR, 2'h2, PC_INC, 3'h1);
		add(12'h165, ALU_AND, 2'h1, PC_INC, 3'h1);
		add(12'h18a, ALU_XOR, 2'h2, PC_INC, 3'h1);
		add(12'h1e1, ALU_ADD, 2'h1, PC_INC, 3'h7, 3'h4);
		add(12'h1c1, ALU_ADD, 2'h2, PC_INC, 3'h7, 3'h4);
		add(12'h21f, ALU_MOVE, 2'h2, PC_INC, 3'h1);
		add(12'h27f, ALU_COM, 2'h1, PC_INC, 3'h1);
		add(12'h283, ALU_INC, 2'h2, PC_INC, 3'h1);
		add(12'h2e3, ALU_DEC, 2'h1, PC_INC, 3'h0);
		add(12'h2e3, ALU_DEC, 2'h1, PC_INC, 3'h0, 3'h1, 1'h1);
		dis(12'hc55);
		add(12'h304, ALU_RRC, 2'h2, PC_INC, 3'h4);
		add(12'h364, ALU_RLC, 2'h1, PC_INC, 3'h4);
		add(12'h384, ALU_SWAP, 2'h2, PC_INC, 3'h0);
		add(12'h3e4, ALU_INC, 2'h1, PC_INC, 3'h0, 3'h1, 1'h1);
		dis(12'ha00);
		add(12'h4e1, ALU_BCLR, 2'h1, PC_INC, 3'h0, 3'h4);
		add(12'h501, ALU_BSET, 2'h1, PC_INC, 3'h0);
		add(12'h6a5, any_alu, 2'h0, PC_INC, 3'h0, 3'h2);
		add(12'h6a5, any_alu, 2'h0, PC_INC, 3'h0, 3'h0, 1'h1);
		dis(12'h003);
		add(12'h7c5, any_alu, 2'h0, PC_INC, 3'h0, 3'h2, 1'h1);
		dis(12'he00);
		add(12'h7c5, any_alu, 2'h0, PC_INC, 3'h0);
		add(12'hc5a, ALU_LIT, 2'h2, PC_INC, 3'h0);
		add(12'hda5, ALU_OR, 2'h2, PC_INC, 3'h1);
		add(12'hff0, ALU_XOR, 2'h2, PC_INC, 3'h1);
		add(12'h021, ALU_PASS_ACC, 2'h1, PC_INC, 3'h0, 3'h4);
		add(12'h022, ALU_PASS_ACC, 2'h1, PC_FILE, 3'h0, 3'h0, 1'h1);
		dis(12'h000);
		add(12'h067, ALU_ZERO, 2'h1, PC_INC, 3'h1);
		add(12'h040, ALU_ZERO, 2'h2, PC_INC, 3'h1);
		add(12'h0a3, ALU_SUB, 2'h1, PC_INC, 3'h7);
		add(12'h0c3, ALU_DEC, 2'h2, PC_INC, 3'h1);
		add(12'h812, any_alu, 2'h2, PC_RET, 3'h0, 3'h0, 1'h1);
		dis(12'hc00);
		add(12'h934, any_alu, 2'h0, PC_CALL, 3'h0, 3'h0, 1'h1);
		dis(12'hc00);
		add(12'hb45, any_alu, 2'h0, PC_GOTO, 3'h0, 3'h0, 1'h1);
		dis(12'hc00);
		add(12'h002, any_alu, 2'h0, PC_INC, 3'h0);
		add(12'h006, any_alu, 2'h0, PC_INC, 3'h0);
		add(12'h005, any_alu, 2'h0, PC_INC, 3'h0);
		add(12'h003, any_alu, 2'h0, PC_INC, 3'h0);
		add(12'h004, any_alu, 2'h0, PC_INC, 3'h0);
		add(12'h003, any_alu, 2'h0, PC_INC, 3'h0);
		repeat (16) @(negedge mclk);
		chk_reset();
		rst_n = 1'b1;
		st = 2'h3;
		dp = 1'b0;
		{prescaler_on_timer, file_bit_value, alu_zero} = rows[0].in;
		// Walk slot by slot: decode after the take, skip outcome after the end strobe
		foreach (rows[i]) begin
			e = rows[i];
			wait_for(1'b0, k);
			chk("start_gap", k, (i > 0) ? 1 : 5);
			@(negedge mclk);
			chk("discard_run", discard, dp);
			if (dp) chk("nop", {ctl.alu, ctl.skip, ctl.pc_op, ctl.acc_write, ctl.file_write}, 0);
			else chk_word(e);
			wait_for(1'b1, k);
			chk("end_gap", k, 3);
			@(negedge mclk);
			if (!dp && e.w == 12'h003) st = 2'h2;
			if (!dp && e.w == 12'h004) st = 2'h3;
			dp = dp ? 1'b0 : e.dn;
			chk("discard_set", discard, dp);
			chk("status", {timeout_status_bit, powerdown_status_bit}, st);
			if (i + 1 < rows.size()) {prescaler_on_timer, file_bit_value, alu_zero} = rows[i + 1].in;
		end
		// A second reset in mid-run must at once clear ctl, discard and the strobes, and set both status bits
		rst_n = 1'b0;
		#1;
		chk_reset();
		// Release again: the first take must come on the fifth edge, as after power-up
		@(negedge mclk);
		rst_n = 1'b1;
		wait_for(1'b0, k);
		chk("restart_gap", k, 5);
		results();
	end

	// Watchdog: the program needs about 215 clocks, so 2000 is ample
	initial begin
		#20000;
		errors++;
		results();
	end
endmodule
`default_nettype wire
